/* File: lsr_pkg.sv */
// Shared constants for the recirculating lamp shift register pair
package lsr_pkg;
    // =========================================
    // Geometry
    localparam int STAGES = 10;
    localparam int ROW_DEVICES = 20;
    localparam int ROW_STAGES = 198;
    localparam int ROWS = 7;
    localparam int CHAR_COLS = 5;
    localparam int COLS_PER_CHAR = 6;
    // =========================================
    // Timing at 20 MHz reference clock
    localparam int CLK_HZ = 20000000;
    localparam int FAST_HZ = 250000;
    localparam int SLOW_HZ = 2;
    localparam int REFRESH_PERIOD_MS = 20;
    localparam int REFRESH_ON_MS = 5;
    localparam int FAST_HALF = CLK_HZ / FAST_HZ / 2;
    localparam int SLOW_HALF = CLK_HZ / SLOW_HZ / 2;
    localparam int REFRESH_CYC = CLK_HZ / 1000 * REFRESH_PERIOD_MS;
    localparam int REFRESH_ON_CYC = CLK_HZ / 1000 * REFRESH_ON_MS;
endpackage

/* File: lsr_if.sv */
// Link between lamp register chain and its controller
`timescale 1ns/1ns
`default_nettype none
interface lsr_if;
    logic shift_clk;
    logic load_sel;
    logic [lsr_pkg::ROWS-1:0] ser_in;
    logic [lsr_pkg::ROWS-1:0] ser_out;
    logic lamp_gate;
    modport dev (input shift_clk, input ser_in, output ser_out);
    modport ctl (output shift_clk, output load_sel, output ser_in,
                 input ser_out, output lamp_gate);
endinterface
`default_nettype wire

/* File: lsr_ctrl.sv */
// Display controller: clock rates, input selectors, refresh gate
`timescale 1ns/1ns
`default_nettype none
module lsr_ctrl #(
    parameter int FAST_HALF = lsr_pkg::FAST_HALF,
    parameter int SLOW_HALF = lsr_pkg::SLOW_HALF,
    parameter int REFRESH_CYC = lsr_pkg::REFRESH_CYC,
    parameter int REFRESH_ON_CYC = lsr_pkg::REFRESH_ON_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_load_req,
    input wire logic i_hold,
    input wire logic [lsr_pkg::ROWS-1:0] i_col_bits,
    output logic o_col_take,
    output logic o_loading,
    lsr_if.ctl link
);
    typedef enum logic [1:0] {LSR_IDLE = 2'h0, LSR_LOAD = 2'h1, LSR_SHOW = 2'h3} lsr_st_type;
    lsr_st_type st, next_st;
    logic [31:0] div, next_div;
    logic [31:0] ref_cnt, next_ref_cnt;
    logic [15:0] nbits, next_nbits;
    logic sclk, next_sclk;
    logic sel, next_sel;
    logic [lsr_pkg::ROWS-1:0] dat, next_dat;
    logic gate, next_gate;
    logic tick;
    // =========================================
    // Next state
    always_comb begin
        next_st = st;
        next_div = div + 32'h1;
        next_sclk = sclk;
        next_sel = sel;
        next_dat = dat;
        next_nbits = nbits;
        next_ref_cnt = ref_cnt + 32'h1;
        next_gate = 1'b0;
        tick = 1'b0;
        o_col_take = 1'b0;
        if (ref_cnt >= 32'(REFRESH_CYC - 1)) begin
            next_ref_cnt = 32'h0;
        end
        next_gate = (next_ref_cnt < 32'(REFRESH_ON_CYC));
        if (st == LSR_LOAD) begin
            tick = (div >= 32'(FAST_HALF - 1));
        end else if (st == LSR_SHOW && !i_hold) begin
            tick = (div >= 32'(SLOW_HALF - 1));
        end else begin
            next_div = div;
        end
        if (tick) begin
            next_div = 32'h0;
            next_sclk = ~sclk;
            // selector and data change on falling half, or at load start while clock is low
            if (sclk) begin
                if (st == LSR_LOAD) begin
                    // last column bit already shifted, take no more
                    if (nbits == 16'(lsr_pkg::ROW_STAGES - 1)) begin
                        next_st = LSR_SHOW;
                        next_sel = 1'b0;
                    end else begin
                        next_sel = 1'b1;
                        next_dat = i_col_bits;
                        o_col_take = 1'b1;
                        next_nbits = nbits + 16'h1;
                    end
                end
            end
        end
        if (st != LSR_LOAD && i_load_req && !sclk) begin
            next_st = LSR_LOAD;
            next_nbits = 16'h0;
            next_div = 32'h0;
            // a pending rise is held back while the selector moves
            next_sclk = 1'b0;
            next_sel = 1'b1;
            next_dat = i_col_bits;
            o_col_take = 1'b1;
        end
    end
    // =========================================
    // Registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            st <= LSR_IDLE;
            div <= 32'h0;
            ref_cnt <= 32'(REFRESH_CYC - 1);
            nbits <= 16'h0;
            sclk <= 1'b0;
            sel <= 1'b0;
            dat <= '0;
            gate <= 1'b0;
        end else begin
            st <= next_st;
            div <= next_div;
            ref_cnt <= next_ref_cnt;
            nbits <= next_nbits;
            sclk <= next_sclk;
            sel <= next_sel;
            dat <= next_dat;
            gate <= next_gate;
        end
    end
    // selector closes the loop around each row
    always_comb begin
        for (int r = 0; r < lsr_pkg::ROWS; r++) begin
            link.ser_in[r] = sel ? dat[r] : link.ser_out[r];
        end
    end
    assign link.shift_clk = sclk;
    assign link.load_sel = sel;
    assign link.lamp_gate = gate;
    assign o_loading = (st == LSR_LOAD);
endmodule
`default_nettype wire

/* File: lsr_chain.sv */
// Register chain end: rows of cascaded ten-stage lamp registers
// Function
// - Each clock shifts bits one stage, ten stages
// - Each stage drives its own output switch
// - Static storage; stopped clock holds contents
// - Single-phase clock, two-phase derived internally
// - Select low recirculates, high loads data
// - Controller keeps recirculating until new message
// - Twenty devices chained, loop closed around row
// - Row of 198 stages, six per character; here each row loop is 200 stages and a load shifts in 198 columns
// - Seven rows of 7X5 dots plus space
// - Rows share one clock, own input bits
// - Load fast, then display at 2 Hz
// - Static picture: load fast, stop clock
// - Lamp gate 50 Hz, 25 percent duty
// - Row lengths selectable by chain gating; not done here, every row is fixed at twenty ten-stage devices
`timescale 1ns/1ns
`default_nettype none
module lsr_chain (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    output logic [lsr_pkg::ROWS*lsr_pkg::ROW_DEVICES*lsr_pkg::STAGES-1:0] o_lamp,
    lsr_if.dev link
);
    localparam int LEN = lsr_pkg::ROW_DEVICES * lsr_pkg::STAGES;
    logic [LEN-1:0] row_q [lsr_pkg::ROWS];
    logic [LEN-1:0] next_row [lsr_pkg::ROWS];
    logic [LEN-1:0] mst_q [lsr_pkg::ROWS];
    logic [LEN-1:0] next_mst [lsr_pkg::ROWS];
    logic [1:0] ck_sync, next_ck_sync;
    logic ck_last, next_ck_last;
    logic [lsr_pkg::ROWS-1:0] din_s1, din_s2, next_din_s1, next_din_s2;
    logic master_ph;
    logic slave_ph;
    // =========================================
    // Pin synchronisers and two-phase split
    always_comb begin
        next_ck_sync = {ck_sync[0], link.shift_clk};
        next_din_s1 = link.ser_in;
        next_din_s2 = din_s1;
        next_ck_last = ck_sync[1];
        // rise loads the master cells, fall moves them to the slaves
        master_ph = ck_sync[1] & ~ck_last;
        slave_ph = ~ck_sync[1] & ck_last;
        for (int r = 0; r < lsr_pkg::ROWS; r++) begin
            next_mst[r] = mst_q[r];
            next_row[r] = row_q[r];
            if (master_ph) begin
                next_mst[r] = {row_q[r][LEN-2:0], din_s2[r]};
            end
            if (slave_ph) begin
                next_row[r] = mst_q[r];
            end
        end
    end
    // Edge detector starts at the idle low level of the link clock
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ck_sync <= 2'h0;
            ck_last <= 1'b0;
        end else begin
            ck_sync <= next_ck_sync;
            ck_last <= next_ck_last;
        end
    end
    always_ff @(posedge i_ref_clk) begin
        din_s1 <= next_din_s1;
        din_s2 <= next_din_s2;
        // No reset: storage holds whatever it last shifted
        for (int r = 0; r < lsr_pkg::ROWS; r++) begin
            mst_q[r] <= next_mst[r];
            row_q[r] <= next_row[r];
        end
    end
    // =========================================
    // Outputs
    always_comb begin
        for (int r = 0; r < lsr_pkg::ROWS; r++) begin
            link.ser_out[r] = row_q[r][LEN-1];
            o_lamp[r*LEN +: LEN] = row_q[r];
        end
    end
endmodule
`default_nettype wire

/* File: lsr_link_monitor.sv */
// Checker of the lamp chain link
`timescale 1ns/1ns
`default_nettype none
module lsr_link_monitor (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic shift_clk,
    input wire logic load_sel,
    input wire logic [lsr_pkg::ROWS-1:0] ser_in,
    input wire logic [lsr_pkg::ROWS-1:0] ser_out,
    input wire logic lamp_gate
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // ========================================
    // Link clock, data and gate
    sequence rise_s; $rose(shift_clk); endsequence
    sequence fall_s; $fell(shift_clk); endsequence
    sel_hold_a: assert property (rise_s |-> $stable(load_sel))
        else $error("select moved");
    din_hold_a: assert property (shift_clk && $past(shift_clk) |-> $stable(ser_in))
        else $error("data moved");
    fast_hi_a: assert property (fall_s ##0 load_sel |->
        $past(shift_clk, 4) > $past(shift_clk, 5)) else $error("fast half");
    slow_lo_a: assert property (rise_s ##0 !load_sel |-> !$past(shift_clk, 40))
        else $error("slow half");
    recirc_data_a: assert property (rise_s ##0 !load_sel |-> ser_in == ser_out)
        else $error("no loop");
    out_step_a: assert property (!$stable(ser_out) |->
        $past(shift_clk, 3) < $past(shift_clk, 4)) else $error("stray shift");
    gate_duty_a: assert property ($rose(lamp_gate) |->
        lamp_gate[*2] ##1 !lamp_gate[*6] ##1 lamp_gate) else $error("gate duty");
    reset_idle_a: assert property ($rose(i_resetn) |->
        !shift_clk && !load_sel && !lamp_gate) else $error("not idle");
endmodule
`default_nettype wire

/* File: recirculating_lamp_shift_register_tb_top.sv */
// Testbench of the lamp chain and its controller
`timescale 1ns/1ns
`default_nettype none
module recirculating_lamp_shift_register_tb_top;
    localparam int W = lsr_pkg::ROW_DEVICES * lsr_pkg::STAGES;
    localparam int R = lsr_pkg::ROWS;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_load_req = 1'b0;
    logic i_hold = 1'b0;
    logic [R-1:0] i_col_bits = 7'h00;
    logic o_col_take;
    logic o_loading;
    logic [R*W-1:0] o_lamp;
    logic [W-1:0] m [R];
    logic [W-1:0] q [$];
    logic [R-1:0] cb;
    int n_errors = 0;
    int comparisons = 0;
    int nr = 0;
    int k;
    lsr_if link ();
    lsr_ctrl #(.FAST_HALF(4), .SLOW_HALF(40), .REFRESH_CYC(8), .REFRESH_ON_CYC(2)) i_lsr_ctrl (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_load_req(i_load_req), .i_hold(i_hold),
        .i_col_bits(i_col_bits), .o_col_take(o_col_take), .o_loading(o_loading), .link(link));
    lsr_chain i_lsr_chain (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .o_lamp(o_lamp),
        .link(link));
    lsr_link_monitor i_lsr_link_monitor (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .shift_clk(link.shift_clk), .load_sel(link.load_sel), .ser_in(link.ser_in),
        .ser_out(link.ser_out), .lamp_gate(link.lamp_gate));
    always #25 i_ref_clk = ~i_ref_clk;
    // ========================================
    // Row model: load or rotate on each link rise
    always @(posedge link.shift_clk) begin
        nr++;
        for (int r = 0; r < R; r++) m[r] = {m[r][W-2:0], link.load_sel ? cb[r] : m[r][W-1]};
    end
    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    initial forever begin
        wait (q.size() >= R);
        repeat (12) @(posedge i_ref_clk);
        for (int r = 0; r < R; r++) chk(o_lamp[r*W +: W], q.pop_front());
    end
    task automatic load();
        int n;
        n = 0;
        i_load_req <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (o_col_take === 1'b1) begin
                i_load_req <= 1'b0;
                cb = i_col_bits;
                i_col_bits <= R'($urandom);
                n++;
            end
        end while (n < 2 || o_loading === 1'b1);
        chk(W'(n), W'(lsr_pkg::ROW_STAGES));
    endtask
    task automatic note(input int n);
        repeat (n) @(negedge link.shift_clk);
        for (int r = 0; r < R; r++) q.push_back(m[r]);
    endtask
    task automatic summarize();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ========================================
    // Tests
    initial begin
        void'($urandom(32'hEA76FF03));
        repeat (8) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        load();
        load();
        note(2);
        $display("test load_recirculate done");
        i_hold <= 1'b1;
        repeat (100) @(posedge i_ref_clk);
        k = nr;
        repeat (300) @(posedge i_ref_clk);
        chk(W'(nr), W'(k));
        note(0);
        repeat (20) @(posedge i_ref_clk);
        $display("test static_hold done");
        i_hold <= 1'b0;
        load();
        note(1);
        repeat (20) @(posedge i_ref_clk);
        $display("test reload done");
        summarize();
    end
    initial begin
        #(50 * 12000);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
